// File: charge_ctrl_consts.svh
// Purpose: Offsets, field positions, reset values and timing counts for the charge controller.
// Assumes: Included by bare name; definitions only.
// Notes: Limits are in seconds of the internal timebase.
`ifndef CHARGE_CTRL_CONSTS_SVH
`define CHARGE_CTRL_CONSTS_SVH

`define CLK_PERIOD_NS 25
`define TICK_PERIOD_NS 1000000000
`define TICK_CYCLES_DEF (`TICK_PERIOD_NS / `CLK_PERIOD_NS)
`define TOP_OFF_S 16'h0010
`define PQ_LIMIT_RST 16'h0708
`define FC_LIMIT_RST 16'h2a30

`define OFS_CTRL 4'h0
`define OFS_PQ_LIMIT 4'h4
`define OFS_FC_LIMIT 4'h8
`define OFS_STATUS 4'hc
`define CTRL_TIMERS_OFF 0
`define CTRL_RST 32'h0000_0000
`define RESP_OKAY 2'b00
`define RESP_SLVERR 2'b10

`define SYNC_W 15
`define IN_DISABLE 0
`define IN_VIN_RISE 1
`define IN_VIN_FALL 2
`define IN_OVLO 3
`define IN_BAT_DEAD_LOW 4
`define IN_BAT_DEAD_UP 5
`define IN_BAT_PQ_UP 6
`define IN_BAT_REG 7
`define IN_I_BELOW_DONE 8
`define IN_I_ABOVE_DONE 9
`define IN_DIE_HOT 10
`define IN_DNI_SHORT 11
`define IN_ZONE_LO 12
`define IN_ZONE_HI 14

`define ZONE_COLD_OUT 3'h0
`define ZONE_COOL 3'h1
`define ZONE_NORMAL 3'h2
`define ZONE_WARM 3'h3
`define ZONE_HOT_OUT 3'h4

`define SEL_NONE 2'h0
`define SEL_PREQUAL 2'h1
`define SEL_FAST 2'h2

`endif

// File: charge_ctrl_pkg.sv
// Purpose: Types shared by the charge controller.
// Assumes: Nothing beyond SystemVerilog.
// Notes: State codes are one-hot.
package charge_ctrl_pkg;
   typedef enum logic [9:0] {
      ST_DISABLED = 10'h001,
      ST_DEAD = 10'h002,
      ST_DEAD_PQ = 10'h004,
      ST_PREQUAL = 10'h008,
      ST_FAST_CC = 10'h010,
      ST_FAST_CV = 10'h020,
      ST_TOP_OFF = 10'h040,
      ST_DONE = 10'h080,
      ST_FAULT = 10'h100,
      ST_SUSPEND = 10'h200
   } charge_state_t;
endpackage

// File: liion_charge_state_controller.sv
// Purpose: Charge state sequencer for a single-cell lithium charger with AXI4-Lite registers.
// Assumes: 40 MHz clock; comparator flags arrive asynchronously from the analog section.
// Notes: Behaviour
//
// The AXI4-Lite register port and the register addresses were decided locally.
`timescale 1ns/100ps
`include "charge_ctrl_consts.svh"

module liion_charge_state_controller
   import charge_ctrl_pkg::*;
#(
   parameter int unsigned TICK_CYCLES = `TICK_CYCLES_DEF
) (
   input wire logic clock, // System clock, 40 MHz.
   input wire logic rstn, // Asynchronous reset, active low.
   input wire logic charge_disable_in, // High disables charging.
   input wire logic vin_above_rise, // Input above undervoltage rise level.
   input wire logic vin_above_fall, // Input above undervoltage fall level.
   input wire logic vin_above_ovlo, // Input above overvoltage level.
   input wire logic bat_above_dead_low, // Battery above dead battery low level.
   input wire logic bat_above_dead_up, // Battery above dead battery upper level.
   input wire logic bat_above_pq_up, // Battery above prequal upper level.
   input wire logic bat_at_reg, // Battery at regulation voltage target.
   input wire logic i_below_done, // Charge current below done threshold.
   input wire logic i_above_done_margin, // Charge current above done threshold plus margin.
   input wire logic die_over_limit, // Die temperature above its limit.
   input wire logic done_prequal_short, // Program pin shorted to ground.
   input wire logic [2:0] thermistor_zone, // Thermistor zone code.
   output logic linear_on_ff, // Linear trickle path enable.
   output logic switcher_on_ff, // Switching charger enable.
   output logic [1:0] current_sel_ff, // Current target select.
   output logic half_scale_ff, // Current targets and done threshold at half.
   output logic reduced_vreg_ff, // Reduced regulation voltage target.
   output logic foldback_ff, // Fast current reduced for die temperature.
   output logic [9:0] state_out_ff, // Current charge state code.
   input wire logic [3:0] s_axi_awaddr, // Write address.
   input wire logic s_axi_awvalid, // Write address valid.
   output logic s_axi_awready, // Write address ready.
   input wire logic [31:0] s_axi_wdata, // Write data.
   input wire logic [3:0] s_axi_wstrb, // Write byte strobes.
   input wire logic s_axi_wvalid, // Write data valid.
   output logic s_axi_wready, // Write data ready.
   output logic [1:0] s_axi_bresp, // Write response.
   output logic s_axi_bvalid, // Write response valid.
   input wire logic s_axi_bready, // Write response ready.
   input wire logic [3:0] s_axi_araddr, // Read address.
   input wire logic s_axi_arvalid, // Read address valid.
   output logic s_axi_arready, // Read address ready.
   output logic [31:0] s_axi_rdata, // Read data.
   output logic [1:0] s_axi_rresp, // Read response.
   output logic s_axi_rvalid, // Read data valid.
   input wire logic s_axi_rready // Read data ready.
);

   function automatic logic [31:0] merge_strb(input logic [31:0] old, input logic [31:0] data,
                                              input logic [3:0] strb);
      logic [31:0] res;
      res = old;
      for (int i = 0; i < 4; i++) begin
         if (strb[i]) begin
            res[i*8 +: 8] = data[i*8 +: 8];
         end
      end
      return res;
   endfunction

   function automatic logic is_mapped(input logic [3:0] addr);
      return (addr == `OFS_CTRL) || (addr == `OFS_PQ_LIMIT) || (addr == `OFS_FC_LIMIT) ||
             (addr == `OFS_STATUS);
   endfunction

   // Input synchronisers: a change is accepted once stages two and three agree.
   logic [`SYNC_W-1:0] raw_in;
   logic [`SYNC_W-1:0] s1_ff, s2_ff, s3_ff, clean_ff;
   wire [`SYNC_W-1:0] nxt_clean = (s2_ff & s3_ff) | (clean_ff & (s2_ff | s3_ff));
   assign raw_in = {thermistor_zone, done_prequal_short, die_over_limit, i_above_done_margin,
                    i_below_done, bat_at_reg, bat_above_pq_up, bat_above_dead_up, bat_above_dead_low,
                    vin_above_ovlo, vin_above_fall, vin_above_rise, charge_disable_in};

   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         s1_ff <= '0;
         s2_ff <= '0;
         s3_ff <= '0;
         clean_ff <= '0;
      end else begin
         s1_ff <= raw_in;
         s2_ff <= s1_ff;
         s3_ff <= s2_ff;
         clean_ff <= nxt_clean;
      end
   end

   wire dis = clean_ff[`IN_DISABLE];
   wire vin_rise = clean_ff[`IN_VIN_RISE];
   wire vin_fall = clean_ff[`IN_VIN_FALL];
   wire ovlo = clean_ff[`IN_OVLO];
   wire bat_low_ok = clean_ff[`IN_BAT_DEAD_LOW];
   wire bat_db_ok = clean_ff[`IN_BAT_DEAD_UP];
   wire bat_pq_ok = clean_ff[`IN_BAT_PQ_UP];
   wire bat_reg = clean_ff[`IN_BAT_REG];
   wire i_low = clean_ff[`IN_I_BELOW_DONE];
   wire i_back = clean_ff[`IN_I_ABOVE_DONE];
   wire die_hot = clean_ff[`IN_DIE_HOT];
   wire pin_short = clean_ff[`IN_DNI_SHORT];
   wire [2:0] zone = clean_ff[`IN_ZONE_HI:`IN_ZONE_LO];
   wire zone_ok = (zone != `ZONE_COLD_OUT) && (zone != `ZONE_HOT_OUT);

   // Registers written by software, plus state and timer registers.
   logic [31:0] ctrl_ff, pq_limit_ff, fc_limit_ff;
   charge_state_t state_ff, nxt_state, resume_ff;
   logic [25:0] tick_cnt_ff;
   logic [15:0] pq_cnt_ff, fc_cnt_ff, to_cnt_ff;

   // Timebase: one tick per second of charge time.
   wire tick = (tick_cnt_ff == 26'(TICK_CYCLES - 1));
   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         tick_cnt_ff <= '0;
      end else begin
         tick_cnt_ff <= tick ? 26'h0 : tick_cnt_ff + 26'h1;
      end
   end

   wire in_pq_grp = (state_ff == ST_DEAD) || (state_ff == ST_DEAD_PQ) || (state_ff == ST_PREQUAL);
   wire in_fc_grp = (state_ff == ST_FAST_CC) || (state_ff == ST_FAST_CV);
   wire in_charge = in_pq_grp || in_fc_grp || (state_ff == ST_TOP_OFF);
   wire suspended = (state_ff == ST_SUSPEND);
   wire timers_on = !ctrl_ff[`CTRL_TIMERS_OFF];
   wire pq_expired = timers_on && (pq_cnt_ff >= pq_limit_ff[15:0]);
   wire fc_expired = timers_on && (fc_cnt_ff >= fc_limit_ff[15:0]);
   wire to_expired = (to_cnt_ff >= `TOP_OFF_S);
   wire short_fault = pin_short && ((zone == `ZONE_NORMAL) || (zone == `ZONE_WARM)) &&
                      (state_ff != ST_DEAD) && !die_hot;
   wire suspend_now = in_charge && (!zone_ok || ovlo);

   // Timers only advance in their own phase and hold through a suspend.
   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         pq_cnt_ff <= '0;
         fc_cnt_ff <= '0;
         to_cnt_ff <= '0;
      end else begin
         if (!in_pq_grp && !suspended) begin
            pq_cnt_ff <= '0;
         end else if (in_pq_grp && tick && pq_cnt_ff != 16'hffff) begin
            pq_cnt_ff <= pq_cnt_ff + 16'h1;
         end
         if (!in_fc_grp && state_ff != ST_TOP_OFF && !suspended) begin
            fc_cnt_ff <= '0;
         end else if (in_fc_grp && tick && fc_cnt_ff != 16'hffff) begin
            fc_cnt_ff <= fc_cnt_ff + 16'h1;
         end
         if (state_ff != ST_TOP_OFF && !suspended) begin
            to_cnt_ff <= '0;
         end else if (state_ff == ST_TOP_OFF && tick && !to_expired) begin
            to_cnt_ff <= to_cnt_ff + 16'h1;
         end
      end
   end

   always_comb begin
      nxt_state = state_ff;
      if (dis) begin
         nxt_state = ST_DISABLED;
      end else begin
         case (state_ff)
            ST_DISABLED: begin
               if (vin_rise) begin
                  if (!bat_low_ok) nxt_state = ST_DEAD;
                  else if (!bat_db_ok) nxt_state = ST_DEAD_PQ;
                  else if (!bat_pq_ok) nxt_state = ST_PREQUAL;
                  else nxt_state = ST_FAST_CC;
               end
            end
            ST_FAULT: nxt_state = ST_FAULT;
            default: begin
               if (!vin_fall) begin
                  nxt_state = ST_DISABLED;
               end else if (short_fault) begin
                  nxt_state = ST_FAULT;
               end else if (suspended) begin
                  if (zone_ok && !ovlo) nxt_state = resume_ff;
               end else if (suspend_now) begin
                  nxt_state = ST_SUSPEND;
               end else begin
                  case (state_ff)
                     ST_DEAD: begin
                        if (pq_expired) nxt_state = ST_FAULT;
                        else if (bat_low_ok) nxt_state = ST_DEAD_PQ;
                     end
                     ST_DEAD_PQ: begin
                        if (pq_expired) nxt_state = ST_FAULT;
                        else if (bat_db_ok) nxt_state = ST_PREQUAL;
                     end
                     ST_PREQUAL: begin
                        if (pq_expired) nxt_state = ST_FAULT;
                        else if (bat_pq_ok) nxt_state = ST_FAST_CC;
                     end
                     ST_FAST_CC: begin
                        if (fc_expired) nxt_state = ST_FAULT;
                        else if (bat_reg) nxt_state = ST_FAST_CV;
                     end
                     ST_FAST_CV: begin
                        if (fc_expired) nxt_state = ST_FAULT;
                        else if (i_low) nxt_state = ST_TOP_OFF;
                     end
                     ST_TOP_OFF: begin
                        if (i_back) nxt_state = ST_FAST_CV;
                        else if (to_expired) nxt_state = ST_DONE;
                     end
                     default: nxt_state = state_ff;
                  endcase
               end
            end
         endcase
      end
   end

   wire nxt_pq = (nxt_state == ST_DEAD_PQ) || (nxt_state == ST_PREQUAL);
   wire nxt_fast = (nxt_state == ST_FAST_CC) || (nxt_state == ST_FAST_CV) || (nxt_state == ST_TOP_OFF);
   wire nxt_linear = (nxt_state == ST_DEAD) || (nxt_state == ST_DEAD_PQ);
   wire nxt_switcher = nxt_pq || nxt_fast;
   wire [1:0] nxt_sel = nxt_fast ? `SEL_FAST : (nxt_pq ? `SEL_PREQUAL : `SEL_NONE);

   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         state_ff <= ST_DISABLED;
         resume_ff <= ST_DISABLED;
         linear_on_ff <= 1'b0;
         switcher_on_ff <= 1'b0;
         current_sel_ff <= `SEL_NONE;
         half_scale_ff <= 1'b0;
         reduced_vreg_ff <= 1'b0;
         foldback_ff <= 1'b0;
         state_out_ff <= 10'h001;
      end else begin
         state_ff <= nxt_state;
         if (nxt_state == ST_SUSPEND && !suspended) resume_ff <= state_ff;
         linear_on_ff <= nxt_linear;
         switcher_on_ff <= nxt_switcher;
         current_sel_ff <= nxt_sel;
         half_scale_ff <= (zone == `ZONE_COOL);
         reduced_vreg_ff <= (zone == `ZONE_WARM);
         foldback_ff <= die_hot && nxt_fast;
         state_out_ff <= nxt_state;
      end
   end

   // Register slave: address and data are caught separately and paired afterwards.
   logic aw_hold_ff, w_hold_ff;
   logic [3:0] awaddr_ff;
   logic [31:0] wdata_ff;
   logic [3:0] wstrb_ff;
   wire aw_fire = s_axi_awvalid && s_axi_awready;
   wire w_fire = s_axi_wvalid && s_axi_wready;
   wire ar_fire = s_axi_arvalid && s_axi_arready;
   wire do_write = aw_hold_ff && w_hold_ff && !s_axi_bvalid;
   wire nxt_aw_hold = (aw_hold_ff || aw_fire) && !do_write;
   wire nxt_w_hold = (w_hold_ff || w_fire) && !do_write;
   wire nxt_bvalid = do_write || (s_axi_bvalid && !s_axi_bready);
   wire nxt_rvalid = ar_fire || (s_axi_rvalid && !s_axi_rready);
   wire [31:0] status_word = {16'h0, 1'b0, zone, 2'b0, state_ff};
   wire [31:0] rd_word = (s_axi_araddr == `OFS_CTRL) ? ctrl_ff :
                         (s_axi_araddr == `OFS_PQ_LIMIT) ? pq_limit_ff :
                         (s_axi_araddr == `OFS_FC_LIMIT) ? fc_limit_ff :
                         (s_axi_araddr == `OFS_STATUS) ? status_word : 32'h0;

   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         aw_hold_ff <= 1'b0;
         w_hold_ff <= 1'b0;
         awaddr_ff <= '0;
         wdata_ff <= '0;
         wstrb_ff <= '0;
         s_axi_awready <= 1'b0;
         s_axi_wready <= 1'b0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= `RESP_OKAY;
         s_axi_arready <= 1'b0;
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= '0;
         s_axi_rresp <= `RESP_OKAY;
      end else begin
         aw_hold_ff <= nxt_aw_hold;
         w_hold_ff <= nxt_w_hold;
         if (aw_fire) awaddr_ff <= s_axi_awaddr;
         if (w_fire) wdata_ff <= s_axi_wdata;
         if (w_fire) wstrb_ff <= s_axi_wstrb;
         s_axi_awready <= !nxt_aw_hold && !nxt_bvalid;
         s_axi_wready <= !nxt_w_hold && !nxt_bvalid;
         s_axi_bvalid <= nxt_bvalid;
         if (do_write) s_axi_bresp <= is_mapped(awaddr_ff) ? `RESP_OKAY : `RESP_SLVERR;
         s_axi_arready <= !nxt_rvalid;
         s_axi_rvalid <= nxt_rvalid;
         if (ar_fire) s_axi_rdata <= rd_word;
         if (ar_fire) s_axi_rresp <= is_mapped(s_axi_araddr) ? `RESP_OKAY : `RESP_SLVERR;
      end
   end

   // Limits are 16 bits; the upper half of each word always reads zero.
   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         ctrl_ff <= `CTRL_RST;
         pq_limit_ff <= {16'h0, `PQ_LIMIT_RST};
         fc_limit_ff <= {16'h0, `FC_LIMIT_RST};
      end else if (do_write) begin
         if (awaddr_ff == `OFS_CTRL) ctrl_ff <= merge_strb(ctrl_ff, wdata_ff, wstrb_ff) & 32'h0000_0001;
         if (awaddr_ff == `OFS_PQ_LIMIT) pq_limit_ff <= merge_strb(pq_limit_ff, wdata_ff, wstrb_ff) & 32'h0000_ffff;
         if (awaddr_ff == `OFS_FC_LIMIT) fc_limit_ff <= merge_strb(fc_limit_ff, wdata_ff, wstrb_ff) & 32'h0000_ffff;
      end
   end

   default clocking cb @(posedge clock); endclocking
   default disable iff (!rstn);

   sequence dead_ready_s;
      state_ff == ST_DEAD && bat_low_ok && !dis && vin_fall && zone_ok && !ovlo && !pq_expired;
   endsequence
   sequence dead_pq_s;
      state_ff == ST_DEAD_PQ;
   endsequence

   a_dead_linear_only: assert property (state_ff == ST_DEAD |-> linear_on_ff && !switcher_on_ff)
      else $error("Dead state must use only the trickle path.");
   a_dead_to_pq: assert property (dead_ready_s |=> dead_pq_s)
      else $error("Dead state did not advance on battery rise.");
   a_dead_pq_both: assert property (dead_pq_s |-> linear_on_ff && switcher_on_ff)
      else $error("Combined state must enable both paths.");
   a_prequal_switch_only: assert property (state_ff == ST_PREQUAL |-> !linear_on_ff && switcher_on_ff &&
      current_sel_ff == `SEL_PREQUAL)
      else $error("Prequal state drives wrong paths.");
   a_disable_forces_off: assert property (dis |=> state_ff == ST_DISABLED && !switcher_on_ff)
      else $error("Disable input did not stop charging.");
   a_start_needs_rise: assert property (state_ff == ST_DISABLED && !vin_rise |=> state_ff == ST_DISABLED)
      else $error("Left disabled without rising undervoltage level.");
   a_fault_sticky: assert property (state_ff == ST_FAULT && !dis |=> state_ff == ST_FAULT)
      else $error("Timer fault left without disable cycle.");
   a_suspend_hold: assert property (suspended |=> $stable(pq_cnt_ff) && $stable(fc_cnt_ff))
      else $error("Timers moved while suspended.");
   a_done_from_topoff: assert property ($rose(state_ff == ST_DONE) |-> $past(state_ff) == ST_TOP_OFF &&
      $past(to_cnt_ff) >= `TOP_OFF_S)
      else $error("Done reached without full top-off period.");
   a_half_scale: assert property (zone == `ZONE_COOL |=> half_scale_ff)
      else $error("Cool zone did not halve current targets.");
   a_warm_vreg: assert property (zone == `ZONE_WARM |=> reduced_vreg_ff)
      else $error("Warm zone did not lower the voltage target.");

endmodule

// File: charge_host_model.sv
// Purpose: Host controller that drives the charge disable input.
// Assumes: Same clock as the charger.
// Notes: Always drives the pin, so the line never floats.
`timescale 1ns/100ps
module charge_host_model (
   input wire logic clock, // System clock.
   input wire logic rstn, // Reset, active low.
   input wire logic disable_req, // Bench asks to hold charging off.
   output logic charge_disable_in // High stops charging.
);
   // Held high in reset so charging waits for firmware; a fault with the pin low holds until disable_req goes high.
   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         charge_disable_in <= 1'h1;
      end else begin
         charge_disable_in <= disable_req;
      end
   end
endmodule

// File: liion_charge_state_controller_test.sv
// Purpose: Sequence test of the charge state controller.
// Assumes: Timebase shortened to 4 clocks a tick.
// Notes: Register offsets and limits as set by the designer.
`timescale 1ns/100ps
`include "charge_ctrl_consts.svh"
module liion_charge_state_controller_test;
   import charge_ctrl_pkg::*;
   logic clock = 1'h0, rstn = 1'h0, host_dis = 1'h1, charge_disable_in;
   logic vin_above_rise = 1'h1, vin_above_fall = 1'h1, vin_above_ovlo = 1'h0, bat_above_dead_low = 1'h0;
   logic bat_above_dead_up = 1'h0, bat_above_pq_up = 1'h0, bat_at_reg = 1'h0, i_below_done = 1'h0;
   logic i_above_done_margin = 1'h0, die_over_limit = 1'h0, done_prequal_short = 1'h0;
   logic [2:0] thermistor_zone = 3'h2;
   logic linear_on_ff, switcher_on_ff, half_scale_ff, reduced_vreg_ff, foldback_ff;
   logic [1:0] current_sel_ff, s_axi_bresp, s_axi_rresp;
   logic [9:0] state_out_ff;
   logic [3:0] s_axi_awaddr = 4'h0, s_axi_wstrb = 4'h0, s_axi_araddr = 4'h0;
   logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, rd;
   logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0, s_axi_arvalid = 1'h0;
   logic s_axi_rready = 1'h0, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   int mismatches = 0, tests_run = 0;
   liion_charge_state_controller #(.TICK_CYCLES(4)) i_dut (.*);
   charge_host_model i_host (.clock(clock), .rstn(rstn), .disable_req(host_dis), .charge_disable_in(charge_disable_in));
   initial begin
      forever #12.5 clock = ~clock;
   end
   task stop_test;
      $display("checks %0d mismatches %0d", tests_run, mismatches);
      if (mismatches == 0 && tests_run > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask
   task chk(input logic [31:0] got, input logic [31:0] exp);
      tests_run++;
      if (got !== exp) begin
         mismatches++;
         $display("unexpected at %0t: got %h exp %h", $time, got, exp);
      end
   endtask
   // Waits for a state, then lets registered outputs settle before judging them.
   task wait_st(input charge_state_t s, input int lim);
      int n;
      for (n = 0; n < lim && state_out_ff !== s; n++) @(posedge clock);
      repeat (2) @(posedge clock);
      chk(state_out_ff, s);
      if (n == lim) stop_test;
   endtask
   task axi_wr(input logic [3:0] a, input logic [31:0] d);
      int n;
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_wstrb <= 4'hf;
      s_axi_awvalid <= 1'h1;
      s_axi_wvalid <= 1'h1;
      s_axi_bready <= 1'h1;
      for (n = 0; n < 50 && s_axi_bvalid !== 1'h1; n++) begin
         @(posedge clock);
         if (s_axi_awready) s_axi_awvalid <= 1'h0;
         if (s_axi_wready) s_axi_wvalid <= 1'h0;
      end
      s_axi_bready <= 1'h0;
      chk(s_axi_bresp, `RESP_OKAY);
      if (n == 50) begin
         mismatches++;
         stop_test;
      end
      @(posedge clock);
   endtask
   task axi_rd(input logic [3:0] a);
      int n;
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'h1;
      s_axi_rready <= 1'h1;
      for (n = 0; n < 50 && s_axi_rvalid !== 1'h1; n++) begin
         @(posedge clock);
         if (s_axi_arready) s_axi_arvalid <= 1'h0;
      end
      s_axi_rready <= 1'h0;
      rd = s_axi_rdata;
      if (n == 50) begin
         mismatches++;
         stop_test;
      end
      @(posedge clock);
   endtask
   initial begin
      repeat (12) @(posedge clock);
      rstn <= 1'h1;
      @(posedge clock);
      axi_rd(`OFS_PQ_LIMIT); chk(rd, 32'h708);
      axi_rd(`OFS_FC_LIMIT); chk(rd, 32'h2a30);
      axi_rd(`OFS_CTRL); chk(rd, `CTRL_RST);
      chk(state_out_ff, ST_DISABLED);
      vin_above_rise <= 1'h0;
      host_dis <= 1'h0;
      repeat (12) @(posedge clock);
      chk(state_out_ff, ST_DISABLED);
      vin_above_rise <= 1'h1;
      wait_st(ST_DEAD, 20);
      chk({linear_on_ff, switcher_on_ff}, 2'h2);
      bat_above_dead_low <= 1'h1;
      wait_st(ST_DEAD_PQ, 20);
      chk({linear_on_ff, switcher_on_ff}, 2'h3);
      thermistor_zone <= 3'h1;
      bat_above_dead_up <= 1'h1;
      wait_st(ST_PREQUAL, 20);
      chk({linear_on_ff, switcher_on_ff, current_sel_ff}, {2'h1, `SEL_PREQUAL});
      chk(half_scale_ff, 1'h1);
      bat_above_pq_up <= 1'h1;
      wait_st(ST_FAST_CC, 20);
      chk({current_sel_ff, half_scale_ff}, {`SEL_FAST, 1'h1});
      thermistor_zone <= 3'h3;
      die_over_limit <= 1'h1;
      repeat (8) @(posedge clock);
      chk({foldback_ff, reduced_vreg_ff, half_scale_ff}, 3'h6);
      die_over_limit <= 1'h0;
      thermistor_zone <= 3'h4;
      wait_st(ST_SUSPEND, 20);
      chk(switcher_on_ff, 1'h0);
      thermistor_zone <= 3'h2;
      wait_st(ST_FAST_CC, 20);
      vin_above_ovlo <= 1'h1;
      wait_st(ST_SUSPEND, 20);
      vin_above_ovlo <= 1'h0;
      wait_st(ST_FAST_CC, 20);
      $display("test charge path done");
      bat_at_reg <= 1'h1;
      wait_st(ST_FAST_CV, 20);
      i_below_done <= 1'h1;
      wait_st(ST_TOP_OFF, 20);
      i_below_done <= 1'h0;
      i_above_done_margin <= 1'h1;
      wait_st(ST_FAST_CV, 20);
      i_above_done_margin <= 1'h0;
      i_below_done <= 1'h1;
      wait_st(ST_TOP_OFF, 20);
      repeat (50) @(posedge clock);
      chk(state_out_ff, ST_TOP_OFF);
      wait_st(ST_DONE, 30);
      $display("test top-off done");
      host_dis <= 1'h1;
      {bat_above_dead_low, bat_above_dead_up, bat_above_pq_up, bat_at_reg, i_below_done} <= 5'h0;
      wait_st(ST_DISABLED, 20);
      host_dis <= 1'h0;
      done_prequal_short <= 1'h1;
      wait_st(ST_DEAD, 20);
      repeat (10) @(posedge clock);
      chk(state_out_ff, ST_DEAD);
      done_prequal_short <= 1'h0;
      {bat_above_dead_low, bat_above_dead_up} <= 2'h3;
      wait_st(ST_PREQUAL, 30);
      done_prequal_short <= 1'h1;
      wait_st(ST_FAULT, 20);
      $display("test pin short done");
      done_prequal_short <= 1'h0;
      host_dis <= 1'h1;
      wait_st(ST_DISABLED, 20);
      axi_wr(`OFS_PQ_LIMIT, 32'h8);
      {bat_above_dead_low, bat_above_dead_up} <= 2'h0;
      host_dis <= 1'h0;
      wait_st(ST_DEAD, 20);
      wait_st(ST_FAULT, 40);
      repeat (10) @(posedge clock);
      chk(state_out_ff, ST_FAULT);
      host_dis <= 1'h1;
      wait_st(ST_DISABLED, 20);
      $display("test timer fault done");
      stop_test;
   end
endmodule
